// >>> bench/receive_parallel_output_port_tb_top.sv
`timescale 1ns/1ps

module receive_parallel_output_port_tb_top;
  localparam logic [4:0] MODES [5] = '{5'b11101, 5'b01111, 5'b10101, 5'b00011, 5'b11000};
  logic               clk_sys, arst_n, src_valid, src_ready;
  rpo_pkg::rpo_char_t src_char;
  logic               char_width_select, codec_bypass_n, fifo_bypass_n;
  logic               ext_fifo_polarity_sel, rx_selftest_enable_n;
  logic               chip_select_n, rx_output_enable, rx_fifo_reset_n;
  logic               clk_out, clk_oe, host_clk, pin, run, want_cs, want_en, want_rst;
  logic [9:0]         rx_char_out;
  logic [1:0]         rx_command_out;
  logic               rx_cmd_or_data_flag, code_violation, rx_bus_oe, rx_fifo_empty_flag;
  // Reference model state
  rpo_pkg::rpo_char_t q[$];
  logic [9:0]         d_h;
  logic [3:0]         c_h;
  logic               kd, kc, ef;
  logic [11:0]        eb, mb;
  int                 err_total, n_tests;

  // Shared clock pin: device drives it in bypass, host otherwise, pull-up when idle
  assign pin = clk_oe ? clk_out : (fifo_bypass_n ? host_clk : 1'b1);

  rpo_top i_rpo_top (.clk_sys(clk_sys), .arst_n(arst_n), .src_char(src_char),
    .src_valid(src_valid), .src_ready(src_ready), .char_width_select(char_width_select),
    .codec_bypass_n(codec_bypass_n), .fifo_bypass_n(fifo_bypass_n),
    .ext_fifo_polarity_sel(ext_fifo_polarity_sel), .rx_selftest_enable_n(rx_selftest_enable_n),
    .chip_select_n(chip_select_n), .rx_output_enable(rx_output_enable),
    .rx_fifo_reset_n(rx_fifo_reset_n), .receive_char_clock_in(pin),
    .receive_char_clock_out(clk_out), .receive_char_clock_oe(clk_oe),
    .rx_char_out(rx_char_out), .rx_command_out(rx_command_out),
    .rx_cmd_or_data_flag(rx_cmd_or_data_flag), .code_violation(code_violation),
    .rx_bus_oe(rx_bus_oe), .rx_fifo_empty_flag(rx_fifo_empty_flag));

  rpo_host_model i_rpo_host_model (.run(run), .pol_hi(ext_fifo_polarity_sel),
    .want_cs(want_cs), .want_en(want_en), .want_rst(want_rst), .pin_clk(pin),
    .host_clk(host_clk), .chip_select_n(chip_select_n),
    .rx_output_enable(rx_output_enable), .rx_fifo_reset_n(rx_fifo_reset_n));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic cmp_bus(input logic [11:0] a, input logic [11:0] e, input logic [11:0] m);
    n_tests++;
    if (((a ^ e) & m) !== 12'h000) begin
      err_total++;
      $display("MISMATCH t=%0t bus act=%h exp=%h mask=%h", $time, a, e, m);
    end
  endtask

  task automatic cmp_bit(input logic a, input logic e);
    n_tests++;
    if (a !== e) begin
      err_total++;
      $display("MISMATCH t=%0t bit act=%h exp=%h", $time, a, e);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Wait for clock pin edges, then let sync and answer settle
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge pin);
      repeat (8) @(posedge clk_sys);
    end
  endtask

  function automatic rpo_pkg::rpo_char_t rnd(input logic cmd, input logic v);
    rpo_pkg::rpo_char_t c;
    c = rpo_pkg::rpo_char_t'(29'($urandom));
    c.is_cmd = cmd;
    // The flag that the mode ignores is set opposite, so a wrong pick shows
    c.viol = v ^ !rx_selftest_enable_n;
    c.mismatch = v ^ rx_selftest_enable_n;
    return c;
  endfunction

  task automatic set_mode(input logic [4:0] m);
    @(posedge clk_sys);
    {char_width_select, codec_bypass_n, fifo_bypass_n, ext_fifo_polarity_sel,
     rx_selftest_enable_n} <= m;
    kd = 1'b0;
    kc = 1'b0;
    mb = 12'h000;
    repeat (30) @(posedge clk_sys);
  endtask

  // Offer one character; gives up after a bounded wait, as when full
  task automatic push(input rpo_pkg::rpo_char_t c, output logic ok);
    int k;
    @(posedge clk_sys);
    src_char <= c;
    src_valid <= 1'b1;
    k = 0;
    ok = 1'b0;
    while (!ok && k < 20) begin
      @(posedge clk_sys);
      ok = (src_ready === 1'b1);
      k++;
    end
    src_valid <= 1'b0;
    if (ok) q.push_back(c);
  endtask

  // Select, one enabled edge, release; model updates the expected pins
  task automatic read_one();
    rpo_pkg::rpo_char_t c;
    logic               ve;
    run = 1'b1;
    want_cs = 1'b1;
    edges(1);
    want_en = 1'b1;
    edges(1);
    want_en = 1'b0;
    edges(1);
    c = q.pop_front();
    ve = !rx_selftest_enable_n ? c.mismatch : (codec_bypass_n & c.viol);
    if (!ve && !codec_bypass_n) begin
      kd = 1'b0;
      kc = 1'b0;
      ef = 1'b0;
      eb = {(char_width_select ? 2'b00 : c.raw[11:10]), c.raw[9:0]};
      mb = 12'hFFF;
    end else if (!ve && c.is_cmd) begin
      c_h = c.cmd;
      kc = 1'b1;
      ef = 1'b1;
    end else if (!ve) begin
      d_h = c.data;
      kd = 1'b1;
      ef = 1'b0;
    end
    if (codec_bypass_n) begin
      eb = char_width_select ? {c_h[1:0], c_h[2], c_h[3], d_h[7:0]} : {c_h[1:0], d_h};
      mb = char_width_select ? {{4{kc}}, {8{kd}}} : {{2{kc}}, {10{kd}}};
    end
    cmp_bit(rx_bus_oe, 1'b1);
    cmp_bus({rx_command_out, rx_char_out}, eb, mb);
    cmp_bit(code_violation, ve);
    if (!ve) cmp_bit(rx_cmd_or_data_flag, ef);
    want_cs = 1'b0;
    edges(1);
    cmp_bit(rx_bus_oe, 1'b0);
    cmp_bit(code_violation, 1'b0);
    run = 1'b0;
  endtask

  // Hold reset low for n sampled edges with enable off and chip select low
  task automatic reset_seq(input int n, input logic hit);
    run = 1'b1;
    want_cs = 1'b1;
    want_rst = 1'b1;
    edges(n);
    want_rst = 1'b0;
    edges(1);
    cmp_bit(src_ready, !hit);
    cmp_bit(rx_fifo_empty_flag, hit);
    edges(1);
    cmp_bit(rx_fifo_empty_flag, hit);
    want_cs = 1'b0;
    run = 1'b0;
    if (hit) q.delete();
  endtask

  // Hang guard, about ten times the expected run
  initial begin
    #200000;
    err_total++;
    $display("Watchdog expired");
    close_out();
  end

  initial begin
    logic ok;
    int   i;
    int   m;
    {arst_n, src_valid, src_char, run, want_cs, want_en, want_rst} = '0;
    {char_width_select, codec_bypass_n, fifo_bypass_n, ext_fifo_polarity_sel} = 4'hF;
    rx_selftest_enable_n = 1'b1;
    err_total = 0;
    n_tests = 0;
    i = $urandom(92639);
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Each width, decode, polarity and clock mode, with a violation in the stream
    for (m = 0; m < 5; m++) begin
      set_mode(MODES[m]);
      for (i = 0; i < 6; i++) begin
        push(rnd(i == 1 || (i > 2 && $urandom % 2 == 1), i == 4), ok);
        if (i == 0 && !fifo_bypass_n) reset_seq(7, 1'b0);
        read_one();
      end
      $display("Mode %0d done", m);
    end
    // Fill until refused while the host stalls, then drain
    set_mode(5'b01101);
    i = 0;
    ok = 1'b1;
    while (ok) begin
      push(rnd($urandom % 2 == 1, 1'b0), ok);
      i += int'(ok);
    end
    cmp_bus(12'(i), 12'h008, 12'hFFF);
    cmp_bit(rx_fifo_empty_flag, 1'b0);
    repeat (8) read_one();
    cmp_bit(rx_fifo_empty_flag, 1'b1);
    $display("Fill and drain done");
    // Six samples fall short, seven start the reset
    push(rnd(1'b0, 1'b0), ok);
    push(rnd(1'b1, 1'b0), ok);
    reset_seq(6, 1'b0);
    reset_seq(7, 1'b1);
    push(rnd(1'b0, 1'b0), ok);
    read_one();
    $display("FIFO reset done");
    close_out();
  end
endmodule

// >>> bench/rpo_host_model.sv
`timescale 1ns/1ps

// Host reading the receive port. It makes the character clock in FIFO mode.
// It moves its pins just after each rising edge of the clock pin.
module rpo_host_model (
  // Requests from the bench
  input  wire logic run,
  input  wire logic pol_hi,
  input  wire logic want_cs,
  input  wire logic want_en,
  input  wire logic want_rst,
  // Clock pin level and host pins
  input  wire logic pin_clk,
  output logic      host_clk,
  output logic      chip_select_n,
  output logic      rx_output_enable,
  output logic      rx_fifo_reset_n
);
  // Clock stands low between bursts, so no stray edge can read a character
  initial begin
    host_clk = 1'b0;
    forever begin
      #62.5;
      host_clk = run ? ~host_clk : 1'b0;
    end
  end

  // Pins change a little over one system clock after an edge. The device
  // synchronises clock and pins together, so an earlier change could be seen
  // at the very edge that must still find the old value.
  // A polarity change also refreshes the enable while the clock stands still.
  // select, enable, reset
  initial begin
    chip_select_n    = 1'b1;
    rx_output_enable = 1'b1;
    rx_fifo_reset_n  = 1'b1;
    forever begin
      @(posedge pin_clk or pol_hi);
      #5.25;
      chip_select_n    = ~want_cs;
      rx_output_enable = ~(want_en ^ pol_hi);
      rx_fifo_reset_n  = ~want_rst;
    end
  end
endmodule

// >>> src/rpo_fifo.sv
`timescale 1ns/1ps

module rpo_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         clear,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  logic         push;
  logic         pop;

  // Full when the pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign push      = in_valid && in_ready && !clear;
  assign pop       = out_valid && out_ready && !clear;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  // Storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
    end else if (clear) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
    end
  end

  // Read pointer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_reg <= '0;
    end else if (clear) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
    end
  end

endmodule

// >>> src/rpo_map.svh
`ifndef RPO_MAP_SVH
`define RPO_MAP_SVH

// System clock period and the character clock made when the FIFO is bypassed
`define RPO_CLK_SYS_NS      4
`define RPO_CHAR_CLK_NS     40
`define RPO_CHAR_CYC        ((`RPO_CHAR_CLK_NS) / (`RPO_CLK_SYS_NS))
`define RPO_CHAR_HALF       ((`RPO_CHAR_CYC) / 2)

// Receive FIFO reset: consecutive sampled character clocks with reset low
`define RPO_RESET_SAMPLES   7

// Character buffer
`define RPO_FIFO_DEPTH      8

// Bit positions inside the synchronised pin vector
`define RPO_SY_HCLK         8
`define RPO_SY_OE           7
`define RPO_SY_RST_N        6
`define RPO_SY_CS_N         5
`define RPO_SY_W8           4
`define RPO_SY_DEC          3
`define RPO_SY_FIFO         2
`define RPO_SY_POL          1
`define RPO_SY_BIST_N       0
`define RPO_SY_WIDTH        9

// Reset values of the output registers
`define RPO_PINS_RST        12'h000
`define RPO_DATA_RST        10'h000
`define RPO_CMD_RST         4'h0

`endif

// >>> src/rpo_pkg.sv
package rpo_pkg;

  // One received character as handed over by the decoder
  typedef struct packed {
    logic [11:0] raw;       // Undecoded 10- or 12-bit character
    logic [9:0]  data;      // Decoded data value
    logic [3:0]  cmd;       // Decoded command value
    logic        is_cmd;    // Character is a command
    logic        viol;      // Coding rule broken
    logic        mismatch;  // Self-test compare failed
  } rpo_char_t;

  // Static configuration after synchronisation
  typedef struct packed {
    logic w8;       // Eight-bit characters
    logic dec_en;   // Decoder in use
    logic fifo_en;  // Receive FIFO in use
    logic pol_hi;   // Output enable active high
    logic bist;     // Self-test running
  } rpo_mode_t;

  // FIFO reset sequencer
  typedef enum logic [2:0] {
    RST_RUN   = 3'b001,
    RST_ARM   = 3'b010,
    RST_FLUSH = 3'b100
  } rpo_rst_state_t;

endpackage

// >>> src/rpo_top.sv
`timescale 1ns/1ps
`include "rpo_map.svh"

// Overview of operation
// RULE_01: Eight-bit decoded: pins nine and eight carry command bits two and three.
// RULE_02: Ten-bit decoded: pins nine and eight carry data bits nine and eight.
// RULE_03: Bypassed decoder: pins nine and eight carry raw bits nine and eight.
// RULE_04: Decoded: pins eleven and ten carry command bits one and zero.
// RULE_05: Eight-bit bypassed: pins eleven and ten are driven low.
// RULE_06: Ten-bit bypassed: pins eleven and ten carry raw bits eleven and ten.
// RULE_07: Outputs change on the rising edge of the character clock.
// RULE_08: Output enable three-states data, command, flag and violation pins.
// RULE_09: Select after chip select low; drive next edge, release on deassert.
// RULE_10: Output enable polarity follows the external FIFO select input.
// RULE_11: A character is delivered after each edge with enable active.
// RULE_12: Eight-bit: flag high means new command, low means new data.
// RULE_13: Ten-bit: flag high means new command, low means new data.
// RULE_14: Bypassed decoder: command or data flag has no function.
// RULE_15: Violation pulses one character period, data and command held.
// RULE_16: In self-test the violation pin reports compare mismatches.
// RULE_17: Bypassed decoder holds violation low; enable three-states it.
// RULE_18: Seven sampled clocks of reset low with conditions start FIFO reset.
// RULE_19: Reset raises empty flag and zeroes counters and pointers.
// RULE_20: Empty flag stays high until a new character is written.
// RULE_21: While reset stays low the FIFO stores nothing.
// RULE_22: With FIFO bypassed the reset input is ignored.
// RULE_23: Bypassed FIFO: device drives a free running character clock.
// RULE_24: Commands leave the low eight data pins undisturbed.
// RULE_25: Enable and reset inputs are sampled on character clock rises.
// RULE_26: Every output holds its last value between updates.
module rpo_top (
  // System clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // Characters from the decoder
  input  wire rpo_pkg::rpo_char_t src_char,
  input  wire logic              src_valid,
  output logic                   src_ready,
  // Static configuration pins
  input  wire logic              char_width_select,
  input  wire logic              codec_bypass_n,
  input  wire logic              fifo_bypass_n,
  input  wire logic              ext_fifo_polarity_sel,
  input  wire logic              rx_selftest_enable_n,
  // Host control pins
  input  wire logic              chip_select_n,
  input  wire logic              rx_output_enable,
  input  wire logic              rx_fifo_reset_n,
  // Character clock pin
  input  wire logic              receive_char_clock_in,
  output logic                   receive_char_clock_out,
  output logic                   receive_char_clock_oe,
  // Parallel receive outputs
  output logic [9:0]             rx_char_out,
  output logic [1:0]             rx_command_out,
  output logic                   rx_cmd_or_data_flag,
  output logic                   code_violation,
  output logic                   rx_bus_oe,
  // Status
  output logic                   rx_fifo_empty_flag
);

  localparam logic [3:0] CHAR_CYC  = 4'(`RPO_CHAR_CYC);
  localparam logic [3:0] CHAR_HALF = 4'(`RPO_CHAR_HALF);
  localparam logic [2:0] RST_LAST  = 3'(`RPO_RESET_SAMPLES - 1);

  // Map held decoded values or a raw character onto the twelve pins
  function automatic logic [11:0] pin_map(input logic        w8,
                                          input logic        dec,
                                          input logic [9:0]  d,
                                          input logic [3:0]  c,
                                          input logic [11:0] raw);
    logic [11:0] p;
    p = 12'h000;
    if (!dec) begin
      // RULE_03: raw ninth and tenth bits
      p[9:0] = raw[9:0];
      // RULE_05: eight-bit bypass drives low; RULE_06: raw top bits
      p[11:10] = w8 ? 2'h0 : raw[11:10];
    end else begin
      // RULE_04: command bits one and zero on upper pins
      p[11:10] = c[1:0];
      // RULE_24: low data pins always carry held data
      p[7:0] = d[7:0];
      if (w8) begin
        // RULE_01: command bits two and three, swapped order
        p[9] = c[2];
        p[8] = c[3];
      end else begin
        // RULE_02: data bits nine and eight
        p[9:8] = d[9:8];
      end
    end
    return p;
  endfunction

  logic [`RPO_SY_WIDTH-1:0] sy1_reg;
  logic [`RPO_SY_WIDTH-1:0] sy2_reg;
  logic [`RPO_SY_WIDTH-1:0] pin_raw;
  rpo_pkg::rpo_mode_t       mode;
  logic                     hclk_d_reg;
  logic                     host_rise;
  logic [3:0]               div_cnt_reg;
  logic                     div_rise;
  logic                     clk_out_reg;
  logic                     rx_edge;
  logic                     en_active;
  logic                     cs_low;
  logic                     rst_low;
  logic                     cs_seen_reg;
  logic                     drive_reg;
  logic                     take;
  logic                     pop;
  logic                     viol_now;
  logic [11:0]              pins_reg;
  logic [9:0]               data_reg;
  logic [3:0]               cmd_reg;
  logic                     flag_reg;
  logic                     viol_reg;
  rpo_pkg::rpo_rst_state_t  rst_state_reg;
  logic [2:0]               rst_cnt_reg;
  logic                     rst_cond;
  logic                     in_reset;
  logic                     empty_reg;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  rpo_pkg::rpo_char_t       head;

  // Every configuration, host control and clock pin passes two flops before use
  assign pin_raw = {receive_char_clock_in, rx_output_enable, rx_fifo_reset_n,
                    chip_select_n, char_width_select, codec_bypass_n,
                    fifo_bypass_n, ext_fifo_polarity_sel, rx_selftest_enable_n};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
    end else begin
      sy1_reg <= pin_raw;
      sy2_reg <= sy1_reg;
    end
  end

  // Decoded configuration
  assign mode.w8      = sy2_reg[`RPO_SY_W8];
  assign mode.dec_en  = sy2_reg[`RPO_SY_DEC];
  assign mode.fifo_en = sy2_reg[`RPO_SY_FIFO];
  assign mode.pol_hi  = sy2_reg[`RPO_SY_POL];
  assign mode.bist    = !sy2_reg[`RPO_SY_BIST_N];
  assign cs_low       = !sy2_reg[`RPO_SY_CS_N];
  assign rst_low      = !sy2_reg[`RPO_SY_RST_N];

  // RULE_10: enable polarity set by the external FIFO select
  assign en_active = mode.pol_hi ? sy2_reg[`RPO_SY_OE] : !sy2_reg[`RPO_SY_OE];

  // Host clock edge finder, reads only the second sync flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hclk_d_reg <= 1'b0;
    end else begin
      hclk_d_reg <= sy2_reg[`RPO_SY_HCLK];
    end
  end
  assign host_rise = sy2_reg[`RPO_SY_HCLK] && !hclk_d_reg;

  // RULE_23: free running character clock divider
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= 4'h0;
      clk_out_reg <= 1'b0;
    end else begin
      div_cnt_reg <= (div_cnt_reg == CHAR_CYC - 4'h1) ? 4'h0 : div_cnt_reg + 4'h1;
      if (div_cnt_reg == CHAR_CYC - 4'h1) begin
        clk_out_reg <= 1'b1;
      end else if (div_cnt_reg == CHAR_HALF - 4'h1) begin
        clk_out_reg <= 1'b0;
      end
    end
  end
  assign div_rise = (div_cnt_reg == CHAR_CYC - 4'h1);

  // RULE_23: pin driven only while the FIFO is bypassed
  assign receive_char_clock_out = clk_out_reg;
  assign receive_char_clock_oe  = !mode.fifo_en;

  // RULE_07: one update event per character clock rise
  // RULE_25: enable and reset looked at only on this event
  assign rx_edge = mode.fifo_en ? host_rise : div_rise;

  // RULE_09: selection follows chip select sampled low one edge earlier
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cs_seen_reg <= 1'b0;
      drive_reg   <= 1'b0;
    end else if (rx_edge) begin
      cs_seen_reg <= cs_low;
      if (!en_active) begin
        drive_reg <= 1'b0;
      end else if (cs_seen_reg) begin
        drive_reg <= 1'b1;
      end
    end
  end

  // RULE_08: one enable for data, command, flag and violation
  assign rx_bus_oe = drive_reg;

  // RULE_11: take a character at each edge with enable active once chip select was seen low or the bus is driven
  assign take     = rx_edge && en_active && (cs_seen_reg || drive_reg);
  assign pop      = take && fifo_out_valid && !in_reset;
  // RULE_16: self-test mismatches take the violation pin
  // RULE_17: no violations while the decoder is bypassed, except self-test mismatches
  assign viol_now = mode.bist ? head.mismatch : (mode.dec_en && head.viol);

  // RULE_15: violation held one character period, outputs frozen
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      viol_reg <= 1'b0;
    end else if (rx_edge) begin
      viol_reg <= pop && viol_now;
    end
  end

  // RULE_12: eight-bit flag and group update
  // RULE_13: ten-bit flag and group update
  // RULE_26: groups hold until the next delivered character
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= `RPO_DATA_RST;
      cmd_reg  <= `RPO_CMD_RST;
      pins_reg <= `RPO_PINS_RST;
      flag_reg <= 1'b0;
    end else if (pop && !viol_now) begin
      if (!mode.dec_en) begin
        // RULE_14: flag has no function in bypass
        flag_reg <= 1'b0;
        pins_reg <= pin_map(mode.w8, 1'b0, data_reg, cmd_reg, head.raw);
      end else if (head.is_cmd) begin
        cmd_reg  <= head.cmd;
        flag_reg <= 1'b1;
        pins_reg <= pin_map(mode.w8, 1'b1, data_reg, head.cmd, head.raw);
      end else begin
        data_reg <= head.data;
        flag_reg <= 1'b0;
        pins_reg <= pin_map(mode.w8, 1'b1, head.data, cmd_reg, head.raw);
      end
    end
  end

  assign rx_char_out         = pins_reg[9:0];
  assign rx_command_out      = pins_reg[11:10];
  assign rx_cmd_or_data_flag = flag_reg;
  assign code_violation      = viol_reg;

  // RULE_18: qualifying conditions for the reset count
  assign rst_cond = mode.fifo_en && rst_low && !en_active && cs_low;

  // RULE_18: count seven sampled clocks then start the reset
  // RULE_22: bypassed FIFO forces the sequencer idle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_state_reg <= rpo_pkg::RST_RUN;
      rst_cnt_reg   <= 3'h0;
    end else if (!mode.fifo_en) begin
      rst_state_reg <= rpo_pkg::RST_RUN;
      rst_cnt_reg   <= 3'h0;
    end else if (rx_edge) begin
      unique case (rst_state_reg)
        rpo_pkg::RST_RUN, rpo_pkg::RST_ARM: begin
          if (!rst_cond) begin
            rst_state_reg <= rpo_pkg::RST_RUN;
            rst_cnt_reg   <= 3'h0;
          end else if (rst_cnt_reg == RST_LAST) begin
            // RULE_19: interface counter zeroed on entry
            rst_state_reg <= rpo_pkg::RST_FLUSH;
            rst_cnt_reg   <= 3'h0;
          end else begin
            rst_state_reg <= rpo_pkg::RST_ARM;
            rst_cnt_reg   <= rst_cnt_reg + 3'h1;
          end
        end
        rpo_pkg::RST_FLUSH: begin
          // RULE_21: reset lasts while the input stays low
          if (!rst_low) begin
            rst_state_reg <= rpo_pkg::RST_RUN;
          end
        end
        default: begin
          rst_state_reg <= rpo_pkg::RST_RUN;
          rst_cnt_reg   <= 3'h0;
        end
      endcase
    end
  end

  assign in_reset = (rst_state_reg == rpo_pkg::RST_FLUSH);

  // RULE_21: no store while in reset; back-pressure reaches the decoder
  assign src_ready = fifo_in_ready && !in_reset;

  // RULE_19: empty raised at once on reset
  // RULE_20: stays raised until a character is written
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      empty_reg <= 1'b1;
    end else begin
      empty_reg <= in_reset || !fifo_out_valid;
    end
  end
  assign rx_fifo_empty_flag = empty_reg;

  // RULE_19: pointers cleared by the reset sequence
  rpo_fifo #(
    .W ($bits(rpo_pkg::rpo_char_t)),
    .D (`RPO_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .clear     (in_reset),
    .in_valid  (src_valid && !in_reset),
    .in_ready  (fifo_in_ready),
    .in_data   (src_char),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (head)
  );

  // Checks kept beside the logic
  AST_VIOL_ONE_PERIOD: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_15
    viol_reg && rx_edge && !(pop && viol_now) |=> !viol_reg)
    else $error("violation outlived one character period");

  AST_VIOL_HOLDS_PINS: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_15
    pop && viol_now |=> viol_reg && (pins_reg == $past(pins_reg)) && $stable(flag_reg))
    else $error("outputs changed on a violating character");

  AST_SELFTEST_REPORT: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_16
    pop && mode.bist && head.mismatch |=> viol_reg)
    else $error("self-test mismatch not reported");

  AST_BYPASS_NO_VIOL: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_17
    rx_edge && !mode.dec_en && !mode.bist |=> !viol_reg)
    else $error("violation raised with decoder bypassed");

  AST_UPPER_LOW_BYP8: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_05
    pop && !viol_now && !mode.dec_en && mode.w8 |=> pins_reg[11:10] == 2'h0 && !flag_reg)
    else $error("upper pins not low in eight-bit bypass");

  AST_CMD_KEEPS_DATA: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_24
    pop && !viol_now && mode.dec_en && head.is_cmd
    |=> flag_reg && (pins_reg[7:0] == $past(pins_reg[7:0])) && (cmd_reg == $past(head.cmd)))
    else $error("command disturbed data pins");

  AST_RESET_AFTER_SEVEN: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_18
    rx_edge && rst_cond && rst_state_reg != rpo_pkg::RST_FLUSH && rst_cnt_reg == RST_LAST
    |=> in_reset)
    else $error("FIFO reset not started after seven samples");

  AST_EMPTY_IN_RESET: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_20
    in_reset |=> rx_fifo_empty_flag ##1 rx_fifo_empty_flag)
    else $error("empty flag dropped during reset");

  AST_NO_STORE_IN_RESET: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_21
    in_reset |-> !src_ready)
    else $error("character accepted while in reset");

  AST_BYPASS_IGNORES_RST: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_22
    !mode.fifo_en |=> !in_reset && rst_cnt_reg == 3'h0)
    else $error("reset sequence ran with FIFO bypassed");

  AST_RELEASE_ON_DEASSERT: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_09
    rx_edge && !en_active |=> !rx_bus_oe)
    else $error("bus still driven after enable dropped");

endmodule
